// >>> core/rx_ctrl_driver.sv
// controller that drives the receiver's static control pins
// assumes pins are plain outputs to the level buffers, one clock domain
//
// Behaviour
// (RQ1) the filter choice goes out as two pins, lsb and msb, both driven here.
// (RQ2) code 00 split, lsb low msb high full, lsb high msb low reduced, 11 chain off.
// (RQ3) each attenuator code is four binary bits worth 2 dB per step, 0 to 30 dB.
// (RQ4) the first attenuator has four pins of its own carrying bits 1 to 4.
// (RQ5) the second attenuator has four more pins independent of the first.
// (RQ6) the low-band attenuator has a third group of four pins.
// (RQ7) four supply pins, one per channel, high means the front end is powered.
// (RQ8) with no command the device sits at full bandwidth and zero attenuation.
// (RQ9) all pins of a setting change together on one edge and then hold.
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctrl_cfg.svh"

module rx_ctrl_driver #(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  // user side: one setting, taken when apply is high and ready is high
  input wire logic apply,
  input wire logic [1:0] filter_code,
  input wire logic [3:0] first_atten_db_code,
  input wire logic [3:0] second_atten_db_code,
  input wire logic [3:0] lowband_atten_db_code,
  input wire logic [3:0] supply_on_req,
  output logic ready,
  output logic [1:0] filter_now,
  // device pins
  output logic filter_select_lsb,
  output logic filter_select_msb,
  output logic first_atten_bit1,
  output logic first_atten_bit2,
  output logic first_atten_bit3,
  output logic first_atten_bit4,
  output logic second_atten_bit1,
  output logic second_atten_bit2,
  output logic second_atten_bit3,
  output logic second_atten_bit4,
  output logic lowband_atten_bit1,
  output logic lowband_atten_bit2,
  output logic lowband_atten_bit3,
  output logic lowband_atten_bit4,
  output logic frontend_supply_on_1,
  output logic frontend_supply_on_2,
  output logic frontend_supply_on_3,
  output logic frontend_supply_on_4
);

  // refuse a settle time the timer cannot count, before any run starts
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("rx_ctrl_driver: SETTLE_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////
  // state and held setting
  rx_ctrl_pkg::setting_s set_r;
  rx_ctrl_pkg::setting_s set_nxt;
  rx_ctrl_pkg::ctrl_state_e state_r;
  rx_ctrl_pkg::ctrl_state_e state_nxt;
  logic ready_r;
  logic busy;
  wire take;
  wire rx_ctrl_pkg::setting_s req;

  // a code is driven as given; the device scales it by the step size
  function automatic logic [3:0] atten_code(input logic [3:0] code);
    atten_code = code & `ATTEN_MAX_CODE; // [RQ3]
  endfunction : atten_code

  ////////////////////////////////////////////////////////////////////
  // request assembly and acceptance
  assign take = apply && ready_r && (state_r == rx_ctrl_pkg::st_idle);
  assign req.filter_sel = filter_code; // [RQ1] [RQ2]
  assign req.first_atten = atten_code(first_atten_db_code); // [RQ4]
  assign req.second_atten = atten_code(second_atten_db_code); // [RQ5]
  assign req.lowband_atten = atten_code(lowband_atten_db_code); // [RQ6]
  assign req.supply_on = supply_on_req; // [RQ7]
  // whole setting replaced at once so no field passes a mixed code
  assign set_nxt = take ? req : set_r; // [RQ9]

  // busy for the settle time after each change, so pins hold steady
  assign state_nxt = take ? rx_ctrl_pkg::st_settle :
                     ((state_r == rx_ctrl_pkg::st_settle) && !busy) ? rx_ctrl_pkg::st_idle : state_r;

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clock(clock),
    .rst_n(rst_n),
    .start(take),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////
  // registers; reset matches the device's own default setting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      set_r <= '{`DEF_FILT, `DEF_ATTEN, `DEF_ATTEN, `DEF_ATTEN, `DEF_SUPPLY}; // [RQ8]
      state_r <= rx_ctrl_pkg::st_idle;
      ready_r <= 1'b0;
    end else begin
      set_r <= set_nxt;
      state_r <= state_nxt;
      ready_r <= (state_nxt == rx_ctrl_pkg::st_idle) && !take;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin outputs, each straight from a flip-flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {filter_select_msb, filter_select_lsb} <= `DEF_FILT; // full bandwidth: lsb low, msb high [RQ8]
      {first_atten_bit4, first_atten_bit3, first_atten_bit2, first_atten_bit1} <= `DEF_ATTEN;
      {second_atten_bit4, second_atten_bit3, second_atten_bit2, second_atten_bit1} <= `DEF_ATTEN;
      {lowband_atten_bit4, lowband_atten_bit3, lowband_atten_bit2, lowband_atten_bit1} <= `DEF_ATTEN;
      {frontend_supply_on_4, frontend_supply_on_3, frontend_supply_on_2, frontend_supply_on_1} <= `DEF_SUPPLY;
      filter_now <= `DEF_FILT;
      ready <= 1'b0;
    end else begin
      filter_select_lsb <= set_nxt.filter_sel[0]; // [RQ1]
      filter_select_msb <= set_nxt.filter_sel[1]; // [RQ1]
      {first_atten_bit4, first_atten_bit3, first_atten_bit2, first_atten_bit1} <= set_nxt.first_atten; // [RQ4]
      {second_atten_bit4, second_atten_bit3, second_atten_bit2, second_atten_bit1} <= set_nxt.second_atten; // [RQ5]
      {lowband_atten_bit4, lowband_atten_bit3, lowband_atten_bit2, lowband_atten_bit1} <= set_nxt.lowband_atten; // [RQ6]
      {frontend_supply_on_4, frontend_supply_on_3, frontend_supply_on_2, frontend_supply_on_1} <= set_nxt.supply_on; // [RQ7]
      filter_now <= set_nxt.filter_sel;
      ready <= (state_nxt == rx_ctrl_pkg::st_idle) && !take;
    end
  end

endmodule : rx_ctrl_driver

`default_nettype wire

// >>> include/rx_ctrl_cfg.svh
// timing and encoding constants for the receiver control-pin driver
// assumes inclusion by bare name from the include path
`ifndef RX_CTRL_CFG_SVH
`define RX_CTRL_CFG_SVH

// filter selection codes, msb first
`define FILT_SPLIT 2'h0
`define FILT_FULL 2'h2
`define FILT_REDUCED 2'h1
`define FILT_OFF 2'h3

// attenuation step in dB and code width
`define ATTEN_STEP_DB 2
`define ATTEN_BITS 4
`define ATTEN_MAX_CODE 4'hF

// default setting: full bandwidth, no attenuation, supplies off
`define DEF_FILT `FILT_FULL
`define DEF_ATTEN 4'h0
`define DEF_SUPPLY 4'h0

// settle time after a change before the next update is accepted, ns
`define SETTLE_NS 1000
`define CLK_PERIOD_NS 20
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> include/rx_ctrl_pkg.sv
// types for the receiver control-pin driver
// assumes rx_ctrl_cfg.svh is on the include path
package rx_ctrl_pkg;

  typedef enum logic [1:0] {
    filt_split = 2'h0,
    filt_reduced = 2'h1,
    filt_full = 2'h2,
    filt_off = 2'h3
  } filter_e;

  // one complete setting of the receiver
  typedef struct packed {
    logic [1:0] filter_sel;
    logic [3:0] first_atten;
    logic [3:0] second_atten;
    logic [3:0] lowband_atten;
    logic [3:0] supply_on;
  } setting_s;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_settle = 1'b1
  } ctrl_state_e;

endpackage : rx_ctrl_pkg

// >>> core/settle_timer.sv
// down-counter that holds busy for a fixed number of cycles after start
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
  parameter int CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);

  localparam int W = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);

  // a zero count would never raise busy, so refuse it at elaboration
  if (CYCLES < 1) begin : g_bad_cycles
    $error("settle_timer: CYCLES must be at least 1");
  end

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  ////////////////////////////////////////////////////////////////////
  // reload on start, else count down to zero
  assign count_nxt = start ? W'(CYCLES) : ((count_r != '0) ? count_r - W'(1) : count_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign busy = (count_r != '0);

endmodule : settle_timer

`default_nettype wire

// >>> tb/rx_ctrl_properties.sv
// checker for the control-pin driver's pin loads
// assumes the bind below attaches it to rx_ctrl_driver
`timescale 1ns/1ps
`default_nettype none
module rx_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic apply,
  input wire logic ready,
  input wire logic [1:0] filter_code,
  input wire logic [3:0] first_atten_db_code,
  input wire logic [3:0] second_atten_db_code,
  input wire logic [3:0] lowband_atten_db_code,
  input wire logic filter_select_lsb,
  input wire logic filter_select_msb,
  input wire logic first_atten_bit1,
  input wire logic second_atten_bit4,
  input wire logic lowband_atten_bit2
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a setting counts only when offered with ready high
  sequence taken; apply && ready; endsequence
  filt_pins_a: assert property (taken |=> {filter_select_msb, filter_select_lsb} == $past(filter_code))
    else $error("filter pins");
  first_pins_a: assert property (taken |=> first_atten_bit1 == $past(first_atten_db_code[0]))
    else $error("first pins");
  second_pins_a: assert property (taken |=> second_atten_bit4 == $past(second_atten_db_code[3]))
    else $error("second pins");
  low_pins_a: assert property (taken |=> lowband_atten_bit2 == $past(lowband_atten_db_code[1]))
    else $error("lowband pins");
  busy_hold_a: assert property (!ready |=> $stable({filter_select_msb, filter_select_lsb, first_atten_bit1}))
    else $error("pins moved while busy");
endmodule : rx_props
////////////////////////////////////////////////////////////
bind rx_ctrl_driver rx_props u_props (.clock, .rst_n, .apply, .ready, .filter_code, .first_atten_db_code,
  .second_atten_db_code, .lowband_atten_db_code, .filter_select_lsb, .filter_select_msb, .first_atten_bit1,
  .second_atten_bit4, .lowband_atten_bit2);
`default_nettype wire

// >>> tb/rx_device_model.sv
// receiver model: decodes the held control levels
// assumes the pins arrive packed as a setting_s
`timescale 1ns/1ps
`default_nettype none
module rx_device_model (
  input wire rx_ctrl_pkg::setting_s pins,
  output rx_ctrl_pkg::filter_e mode,
  output logic [4:0] db1,
  output logic [4:0] db2,
  output logic [4:0] db3,
  output logic [3:0] fee_on
);
  // pure level decode, no clock on the device side
  assign mode = rx_ctrl_pkg::filter_e'(pins.filter_sel);
  assign db1 = {pins.first_atten, 1'b0};
  assign db2 = {pins.second_atten, 1'b0};
  assign db3 = {pins.lowband_atten, 1'b0};
  assign fee_on = pins.supply_on;
endmodule : rx_device_model
`default_nettype wire

// >>> tb/tb.sv
// bench: driver feeding the receiver model, settings loaded by task
// assumes package, design and model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
  int num_errors = 0, comparisons = 0;
  logic clock = 1'b0, rst_n = 1'b0, apply = 1'b0, ready;
  logic [1:0] filter_code = 2'h0, filter_now;
  logic [3:0] first_atten_db_code = 4'h0, second_atten_db_code = 4'h0;
  logic [3:0] lowband_atten_db_code = 4'h0, supply_on_req = 4'h0;
  localparam rx_ctrl_pkg::filter_e exp_mode [4] = '{rx_ctrl_pkg::filt_split, rx_ctrl_pkg::filt_reduced,
    rx_ctrl_pkg::filt_full, rx_ctrl_pkg::filt_off};
  rx_ctrl_pkg::filter_e mode;
  logic [4:0] db1, db2, db3;
  logic [3:0] fee_on;
  wire rx_ctrl_pkg::setting_s pins;
  ////////////////////////////////////////////////////////////
  // short settle keeps the run brief
  rx_ctrl_driver #(.SETTLE_CYCLES(3)) dut (.clock, .rst_n, .apply, .filter_code, .first_atten_db_code,
    .second_atten_db_code, .lowband_atten_db_code, .supply_on_req, .ready, .filter_now,
    .filter_select_lsb(pins.filter_sel[0]), .filter_select_msb(pins.filter_sel[1]),
    .first_atten_bit1(pins.first_atten[0]), .first_atten_bit2(pins.first_atten[1]),
    .first_atten_bit3(pins.first_atten[2]), .first_atten_bit4(pins.first_atten[3]),
    .second_atten_bit1(pins.second_atten[0]), .second_atten_bit2(pins.second_atten[1]),
    .second_atten_bit3(pins.second_atten[2]), .second_atten_bit4(pins.second_atten[3]),
    .lowband_atten_bit1(pins.lowband_atten[0]), .lowband_atten_bit2(pins.lowband_atten[1]),
    .lowband_atten_bit3(pins.lowband_atten[2]), .lowband_atten_bit4(pins.lowband_atten[3]),
    .frontend_supply_on_1(pins.supply_on[0]), .frontend_supply_on_2(pins.supply_on[1]),
    .frontend_supply_on_3(pins.supply_on[2]), .frontend_supply_on_4(pins.supply_on[3]));
  rx_device_model dev (.pins(pins), .mode(mode), .db1(db1), .db2(db2), .db3(db3), .fee_on(fee_on));
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////
  // counts, verdict, end of run
  task automatic stop_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // wait for ready (bounded), then offer one setting for one edge
  task automatic put(input logic [1:0] f, input logic [3:0] a, b, c, s);
    for (int n = 0; ready !== 1'b1; n++) begin
      if (n > 20) begin num_errors++; stop_test; end
      @(negedge clock);
    end
    {filter_code, first_atten_db_code, second_atten_db_code, lowband_atten_db_code, supply_on_req} = {f, a, b, c, s};
    apply = 1'b1;
    @(negedge clock);
    apply = 1'b0;
    @(negedge clock);
  endtask : put
  // what the receiver decodes from the held pins, and the driver's filter_now
  task automatic expect_set(input logic [1:0] f, input logic [3:0] a, b, c, s);
    `CHK("mode", exp_mode[f], mode)
    `CHK("filter_now", f, filter_now)
    `CHK("first_db", {a, 1'b0}, db1)
    `CHK("second_db", {b, 1'b0}, db2)
    `CHK("lowband_db", {c, 1'b0}, db3)
    `CHK("supply", s, fee_on)
  endtask : expect_set
  ////////////////////////////////////////////////////////////
  // reset default, every filter code with edge codes, refusal while busy
  initial begin
    logic [3:0] a;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    expect_set(2'h2, 4'h0, 4'h0, 4'h0, 4'h0);
    $display("test reset_default done");
    for (int i = 0; i < 4; i++) begin
      a = 4'(5 * i);
      put(2'(i), a, ~a, 4'h3 << i, 4'h5 ^ (4'h1 << i));
      expect_set(2'(i), a, ~a, 4'h3 << i, 4'h5 ^ (4'h1 << i));
    end
    $display("test all_modes done");
    put(2'h1, 4'hF, 4'h0, 4'h9, 4'hF);
    apply = 1'b1;
    filter_code = 2'h3;
    repeat (2) @(negedge clock);
    apply = 1'b0;
    expect_set(2'h1, 4'hF, 4'h0, 4'h9, 4'hF);
    $display("test busy_refused done");
    // mid-run reset must bring back the idle default, then accept again
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    expect_set(2'h2, 4'h0, 4'h0, 4'h0, 4'h0);
    rst_n = 1'b1;
    put(2'h0, 4'h1, 4'h2, 4'h4, 4'h8);
    expect_set(2'h0, 4'h1, 4'h2, 4'h4, 4'h8);
    $display("test reset_midrun done");
    stop_test;
  end
endmodule : tb
`default_nettype wire
